// ===== verilog/cic_pkg.sv
// Purpose: shared constants and types of the core interrupt control block
// Assumes: 32 core interrupts, 32-bit APB data
// Notes: addresses are byte addresses on the register bus
package cic_pkg;
  localparam int NUM_IRQ = 32;
  localparam int SID_W = 8;
  localparam int STK_DEPTH = 8;
  localparam int PTR_W = 4;
  localparam logic [4:0] SYSTEM_EVENT_IRQ_NUM = 5'h0f;
  // register byte offsets
  localparam logic [7:0] OFS_SYSCTL = 8'h00;
  localparam logic [7:0] OFS_LATCH = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_MASKP = 8'h0c;
  localparam logic [7:0] OFS_MODE_CONTROL_ONE = 8'h10;
  localparam logic [7:0] OFS_MODE_CONTROL_TWO = 8'h14;
  localparam logic [7:0] OFS_MODE_CLEAR_MASK = 8'h18;
  localparam logic [7:0] OFS_ARITH_STATUS_X = 8'h1c;
  localparam logic [7:0] OFS_ARITH_STATUS_Y = 8'h20;
  localparam logic [7:0] OFS_STKTOP = 8'h24;
  localparam logic [7:0] OFS_SID = 8'h28;
  // field positions
  localparam int SYSCTL_INTERNAL_VECTOR_SELECT_BIT = 0;
  localparam int SYSCTL_EXTERNAL_VECTOR_SELECT_BIT = 1;
  localparam int MODE_CONTROL_ONE_NEST_BIT = 11;
  localparam int MODE_CONTROL_ONE_GIE_BIT = 12;
  localparam int MODE_CONTROL_TWO_SELF_NEST_ENABLE_BIT = 8;
  // reset values
  localparam logic [31:0] SYSCTL_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_CONTROL_ONE_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_CONTROL_TWO_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_CLEAR_MASK_RST = 32'h0000_1000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  // vector table bases and fixed reset routine address, values arbitrary
  localparam logic [31:0] IVT_L1_BASE = 32'h0009_0000;
  localparam logic [31:0] IVT_L2_BASE = 32'h0020_0000;
  localparam logic [31:0] IVT_L3_BASE = 32'h8000_0000;
  localparam logic [31:0] RESET_ADDR = 32'h0020_0004;
  localparam logic [31:0] VEC_STRIDE = 32'h0000_0004;

  typedef struct packed {
    logic [31:0] mode_control_one;
    logic [31:0] arith_status_x;
    logic [31:0] arith_status_y;
    logic [31:0] maskp;
  } stk_entry_s;
endpackage : cic_pkg

// ===== verilog/status_stack_if.sv
// Purpose: carrier between the interrupt control and its status stack
// Assumes: one clock, owner drives requests
// Notes: push and pop are single-cycle strobes
interface status_stack_if;
  import cic_pkg::*;
  logic push;
  logic pop;
  stk_entry_s push_data;
  stk_entry_s top;
  logic top_wr;
  logic [31:0] top_wdata;
  logic empty;
  logic full;
  modport owner (output push, pop, push_data, top_wr, top_wdata, input top, empty, full);
  modport stack (input push, pop, push_data, top_wr, top_wdata, output top, empty, full);
endinterface : status_stack_if

// ===== verilog/status_stack.sv
// Purpose: hardware status stack of mode, arithmetic status and mask pointer
// Assumes: owner never pushes when full nor pops when empty
// Notes: top mode field writable in place
module status_stack import cic_pkg::*; (
  input wire logic CLK,
  input wire logic RST,
  status_stack_if.stack stk
);
  stk_entry_s mem_q [STK_DEPTH];
  logic [PTR_W-1:0] cnt_q;
  logic [PTR_W-1:0] top_idx;

  assign top_idx = cnt_q - 4'h1;
  assign stk.empty = (cnt_q == 4'h0);
  assign stk.full = (cnt_q == 4'(STK_DEPTH));
  assign stk.top = stk.empty ? '0 : mem_q[top_idx[2:0]];

  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt_q <= 4'h0;
    end else if (stk.push && !stk.full) begin
      cnt_q <= cnt_q + 4'h1;
    end else if (stk.pop && !stk.empty) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (stk.push && !stk.full) begin
      mem_q[cnt_q[2:0]] <= stk.push_data;
    end else if (stk.top_wr && !stk.empty) begin
      mem_q[top_idx[2:0]].mode_control_one <= stk.top_wdata;
    end
  end
endmodule : status_stack

// ===== verilog/core_interrupt_control.sv
// Purpose: core interrupt latch, masking, nesting, status push and event-controller link
// Assumes: RTI_EXEC and CLEAR_IRQ_JUMP_EXEC are one-cycle strobes from the sequencer
// Notes: registers over APB, zero wait states, two-cycle transfers
// Notes on behaviour
// RULE_01: vector base chosen from external and internal select bits, three locations.
// RULE_02: reset routine address is a fixed constant, independent of selects.
// RULE_03: internal select set forces table into internal RAM; clear means L2 ROM, or L3 when external select is set.
// RULE_04: latch, mask, mask-pointer registers, bit index equals interrupt number.
// RULE_05: one latch register holds all interrupt latch bits.
// RULE_06: every interrupt entry pushes both arithmetic status and first mode register.
// RULE_07: after push, first mode bits set in clear mask are cleared.
// RULE_08: global enable cleared by entry takes hold before any preemption.
// RULE_09: return and clear-interrupt jump both pop the status stack.
// RULE_10: self-nest enable in second mode register applies to system event only.
// RULE_11: with self-nest, system event may latch while its routine runs.
// RULE_12: self-nesting keeps system event unmasked, lower ones masked.
// RULE_13: system event entry pushes old mask pointer, then sets its bit.
// RULE_14: return from self-nested system event leaves normal pointer clearing aside.
// RULE_15: implicit mask derived from lowest set mask-pointer bit in nest mode.
// RULE_16: system event preempts itself only with global, nest and self-nest set.
// RULE_17: nesting and self-nesting enabled independently by their own bits.
// RULE_18: without self-nest, system event not latched during its own routine.
// RULE_19: control bit changes act within one cycle.
// RULE_20: status stack top mode value readable and writable as a register.
// RULE_21: source identifier read returns the controller's current value.
// RULE_22: any write to source identifier sends an acknowledge pulse.
// RULE_23: lower interrupt number wins when several are pending.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
module core_interrupt_control import cic_pkg::*; (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [NUM_IRQ-1:0] IRQ_IN,
  input wire logic SEC_IRQ,
  input wire logic [SID_W-1:0] SEC_SID,
  output logic SEC_ACK,
  input wire logic RTI_EXEC,
  input wire logic CLEAR_IRQ_JUMP_EXEC,
  output logic VEC_TAKE,
  output logic [4:0] VEC_NUM,
  output logic [31:0] VEC_ADDR,
  output logic [31:0] RESET_VECTOR
);
  status_stack_if stk ();

  status_stack u_stack (
    .CLK(CLK),
    .RST(RST),
    .stk(stk.stack)
  );

  // returns {none, index} of the lowest set bit
  function automatic logic [5:0] lowest_set(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h20;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b0, 5'(i)};
      end
    end
    return r;
  endfunction : lowest_set

  function automatic logic [31:0] implicit_mask(input logic [31:0] mp, input logic nest, input logic self_nest_enable);
    logic [5:0] lo;
    logic [31:0] m;
    lo = lowest_set(mp);
    if (lo[5]) begin
      m = 32'h0000_0000;
    end else if (!nest) begin
      m = 32'hffff_ffff;
    end else if (self_nest_enable && lo[4:0] == SYSTEM_EVENT_IRQ_NUM) begin
      m = 32'hffff_ffff << (SYSTEM_EVENT_IRQ_NUM + 5'h1);
    end else begin
      m = 32'hffff_ffff << lo[4:0];
    end
    return m;
  endfunction : implicit_mask

  function automatic logic addr_ok(input logic [7:0] a);
    return (a <= OFS_SID) && (a[1:0] == 2'b00);
  endfunction : addr_ok

  logic [31:0] sysctl_q;
  logic [31:0] latch_q;
  logic [31:0] latch_d;
  logic [31:0] mask_q;
  logic [31:0] maskp_q;
  logic [31:0] maskp_d;
  logic [31:0] mode_control_one_q;
  logic [31:0] mode_control_one_d;
  logic [31:0] mode_control_two_q;
  logic [31:0] mode_clear_mask_q;
  logic [31:0] arith_status_x_q;
  logic [31:0] arith_status_x_d;
  logic [31:0] arith_status_y_q;
  logic [31:0] arith_status_y_d;
  logic [31:0] prdata_q;
  logic sec_ack_q;
  logic vec_take_q;
  logic [4:0] vec_num_q;
  logic [31:0] vec_addr_q;
  logic wr;
  logic setup;
  logic gie;
  logic nest;
  logic self_nest_enable;
  logic pop;
  logic take;
  logic [31:0] imp_mask;
  logic [31:0] pending;
  logic [5:0] pick;
  logic [5:0] cur;
  logic [31:0] events;
  logic [31:0] ivt_base;

  assign wr = PSEL && PENABLE && PWRITE && addr_ok(PADDR);
  assign setup = PSEL && !PENABLE;
  assign PREADY = PSEL && PENABLE;
  assign PSLVERR = PSEL && PENABLE && !addr_ok(PADDR);
  assign PRDATA = prdata_q;
  assign SEC_ACK = sec_ack_q;
  assign VEC_TAKE = vec_take_q;
  assign VEC_NUM = vec_num_q;
  assign VEC_ADDR = vec_addr_q;
  assign RESET_VECTOR = RESET_ADDR; // RULE_02

  // control bits read straight from registers: a write acts on the next cycle
  assign gie = mode_control_one_q[MODE_CONTROL_ONE_GIE_BIT]; // RULE_19
  assign nest = mode_control_one_q[MODE_CONTROL_ONE_NEST_BIT]; // RULE_17
  assign self_nest_enable = mode_control_two_q[MODE_CONTROL_TWO_SELF_NEST_ENABLE_BIT]; // RULE_10

  always_comb begin
    if (sysctl_q[SYSCTL_INTERNAL_VECTOR_SELECT_BIT]) begin
      ivt_base = IVT_L1_BASE; // RULE_03
    end else if (sysctl_q[SYSCTL_EXTERNAL_VECTOR_SELECT_BIT]) begin
      ivt_base = IVT_L3_BASE; // RULE_01
    end else begin
      ivt_base = IVT_L2_BASE; // RULE_01
    end
  end

  assign imp_mask = implicit_mask(maskp_q, nest, self_nest_enable); // RULE_15
  assign pending = latch_q & mask_q & ~imp_mask & {32{gie}}; // RULE_16
  assign pick = lowest_set(pending); // RULE_23
  assign cur = lowest_set(maskp_q);
  assign pop = (RTI_EXEC || CLEAR_IRQ_JUMP_EXEC) && !stk.empty; // RULE_09
  // a pop owns the stack for its cycle, entry waits one cycle
  assign take = !pick[5] && !pop && !stk.full;

  always_comb begin
    events = IRQ_IN;
    events[SYSTEM_EVENT_IRQ_NUM] = SEC_IRQ && (!maskp_q[SYSTEM_EVENT_IRQ_NUM] || self_nest_enable); // RULE_18 RULE_11
  end

  assign stk.push = take; // RULE_06
  assign stk.pop = pop;
  assign stk.push_data = '{mode_control_one: mode_control_one_q, arith_status_x: arith_status_x_q, arith_status_y: arith_status_y_q, maskp: maskp_q}; // RULE_13
  assign stk.top_wr = wr && PADDR == OFS_STKTOP; // RULE_20
  assign stk.top_wdata = PWDATA;

  // software writes first, hardware clearing of the taken bit next, new events win
  always_comb begin
    latch_d = latch_q;
    if (wr && PADDR == OFS_LATCH) begin
      latch_d = PWDATA;
    end
    if (take) begin
      latch_d[pick[4:0]] = 1'b0;
    end
    latch_d = latch_d | events; // RULE_05
  end

  always_comb begin
    maskp_d = maskp_q;
    if (wr && PADDR == OFS_MASKP) begin
      maskp_d = PWDATA;
    end
    if (pop) begin
      if (RTI_EXEC && self_nest_enable && !cur[5] && cur[4:0] == SYSTEM_EVENT_IRQ_NUM) begin
        maskp_d = stk.top.maskp; // RULE_14
      end else if (!cur[5]) begin
        maskp_d[cur[4:0]] = 1'b0;
      end
    end else if (take) begin
      maskp_d[pick[4:0]] = 1'b1; // RULE_13 RULE_12
    end
  end

  always_comb begin
    mode_control_one_d = mode_control_one_q;
    arith_status_x_d = arith_status_x_q;
    arith_status_y_d = arith_status_y_q;
    if (wr && PADDR == OFS_MODE_CONTROL_ONE) begin
      mode_control_one_d = PWDATA;
    end
    if (wr && PADDR == OFS_ARITH_STATUS_X) begin
      arith_status_x_d = PWDATA;
    end
    if (wr && PADDR == OFS_ARITH_STATUS_Y) begin
      arith_status_y_d = PWDATA;
    end
    if (pop) begin
      mode_control_one_d = stk.top.mode_control_one; // RULE_09
      arith_status_x_d = stk.top.arith_status_x;
      arith_status_y_d = stk.top.arith_status_y;
    end else if (take) begin
      mode_control_one_d = mode_control_one_q & ~mode_clear_mask_q; // RULE_07 RULE_08
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      latch_q <= 32'h0000_0000;
      maskp_q <= 32'h0000_0000;
      mode_control_one_q <= MODE_CONTROL_ONE_RST;
      arith_status_x_q <= 32'h0000_0000;
      arith_status_y_q <= 32'h0000_0000;
    end else begin
      latch_q <= latch_d; // RULE_04
      maskp_q <= maskp_d;
      mode_control_one_q <= mode_control_one_d;
      arith_status_x_q <= arith_status_x_d;
      arith_status_y_q <= arith_status_y_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      sysctl_q <= SYSCTL_RST;
      mask_q <= MASK_RST;
      mode_control_two_q <= MODE_CONTROL_TWO_RST;
      mode_clear_mask_q <= MODE_CLEAR_MASK_RST;
    end else if (wr) begin
      case (PADDR)
        OFS_SYSCTL: sysctl_q <= {30'h0, PWDATA[1:0]};
        OFS_MASK: mask_q <= PWDATA; // RULE_04
        OFS_MODE_CONTROL_TWO: mode_control_two_q <= PWDATA;
        OFS_MODE_CLEAR_MASK: mode_clear_mask_q <= PWDATA;
        default: ;
      endcase
    end
  end

  // read data is captured in the setup cycle and held through the access
  always_ff @(posedge CLK) begin
    if (RST) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      case (PADDR)
        OFS_SYSCTL: prdata_q <= sysctl_q;
        OFS_LATCH: prdata_q <= latch_q;
        OFS_MASK: prdata_q <= mask_q;
        OFS_MASKP: prdata_q <= maskp_q;
        OFS_MODE_CONTROL_ONE: prdata_q <= mode_control_one_q;
        OFS_MODE_CONTROL_TWO: prdata_q <= mode_control_two_q;
        OFS_MODE_CLEAR_MASK: prdata_q <= mode_clear_mask_q;
        OFS_ARITH_STATUS_X: prdata_q <= arith_status_x_q;
        OFS_ARITH_STATUS_Y: prdata_q <= arith_status_y_q;
        OFS_STKTOP: prdata_q <= stk.top.mode_control_one; // RULE_20
        OFS_SID: prdata_q <= {24'h0, SEC_SID}; // RULE_21
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      sec_ack_q <= 1'b0;
    end else begin
      sec_ack_q <= wr && PADDR == OFS_SID; // RULE_22
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      vec_take_q <= 1'b0;
      vec_num_q <= 5'h00;
      vec_addr_q <= 32'h0000_0000;
    end else begin
      vec_take_q <= take;
      if (take) begin
        vec_num_q <= pick[4:0];
        vec_addr_q <= ivt_base + VEC_STRIDE * {27'h0, pick[4:0]}; // RULE_01
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_entry;
    take ##1 VEC_TAKE;
  endsequence

  sequence s_sid_write;
    wr && PADDR == OFS_SID;
  endsequence

  property p_entry_vector;
    logic [4:0] n;
    (take, n = pick[4:0]) |-> s_entry ##0 (VEC_NUM == n) && maskp_q[n];
  endproperty

  entry_vector_a: assert property (p_entry_vector) else $error("entry did not vector or set pointer bit"); // RULE_13

  mode_clear_a: assert property (take |=> (mode_control_one_q & $past(mode_clear_mask_q)) == 32'h0 || $past(wr))
    else $error("mode bits not cleared on entry"); // RULE_07

  gie_block_a: assert property (take && (mode_clear_mask_q[MODE_CONTROL_ONE_GIE_BIT]) && !wr |=> !take)
    else $error("preempted before global disable"); // RULE_08

  sid_ack_a: assert property (s_sid_write |=> SEC_ACK ##1 !SEC_ACK)
    else $error("acknowledge not a single pulse"); // RULE_22

  system_event_irq_block_a: assert property (SEC_IRQ && maskp_q[SYSTEM_EVENT_IRQ_NUM] && !self_nest_enable && !latch_q[SYSTEM_EVENT_IRQ_NUM] && !wr
    |=> !latch_q[SYSTEM_EVENT_IRQ_NUM]) else $error("system event latched during its routine"); // RULE_18

  self_nest_a: assert property (take && pick[4:0] == SYSTEM_EVENT_IRQ_NUM && maskp_q[SYSTEM_EVENT_IRQ_NUM] |-> gie && nest && self_nest_enable)
    else $error("system event self-preempted without all enables"); // RULE_16

  prio_a: assert property (take |-> (pending & ~(32'hffff_ffff << pick[4:0])) == 32'h0)
    else $error("higher priority pending interrupt skipped"); // RULE_23

  pop_restore_a: assert property (pop && !wr |=> mode_control_one_q == $past(stk.top.mode_control_one))
    else $error("mode not restored by pop"); // RULE_09

  ivt_sel_a: assert property (take && sysctl_q[SYSCTL_INTERNAL_VECTOR_SELECT_BIT] |=> VEC_ADDR[31:16] == IVT_L1_BASE[31:16])
    else $error("internal vector select ignored"); // RULE_03

  gie_gate_a: assert property (!gie |-> !take)
    else $error("interrupt taken with global enable clear"); // RULE_19
endmodule : core_interrupt_control

// ===== test/sec_model.sv
// Purpose: behavioural system event controller facing the core
// Assumes: one request outstanding until the core acknowledges it
// Notes: identifier is inverted once released so stale values cannot match
module sec_model import cic_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic raise,
  input wire logic [SID_W-1:0] sid_in,
  input wire logic sec_ack,
  output logic sec_irq,
  output logic [SID_W-1:0] sec_sid,
  output logic [7:0] ack_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wait_q;
  always @(posedge clk) begin
    sec_irq <= 1'b0;
    if (rst) begin
      wait_q <= 1'b0;
      sec_sid <= '0;
      ack_cnt <= 8'h00;
    end else if (sec_ack === 1'b1 && wait_q) begin
      wait_q <= 1'b0;
      sec_sid <= ~sec_sid;
      ack_cnt <= ack_cnt + 8'h01;
    end else if (raise && !wait_q) begin
      wait_q <= 1'b1;
      sec_irq <= 1'b1;
      sec_sid <= sid_in;
    end
  end
endmodule : sec_model

// ===== test/tb_top.sv
// Purpose: self-checking bench of the core interrupt control
// Assumes: zero-wait APB slave, event controller model on the far side
// Notes: vector selection rows first, then nesting and reset cases
module tb_top import cic_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [31:0] sel;
    logic [31:0] base;
  } vrow_s;
  vrow_s vrows [4] = '{'{32'h0, IVT_L2_BASE}, '{32'h2, IVT_L3_BASE}, '{32'h1, IVT_L1_BASE},
    '{32'h3, IVT_L1_BASE}};
  logic clk, rst, psel, penable, pwrite, pslverr, pready, sec_irq, sec_ack, return_from_irq, jci, vec_take, raise, re;
  logic [7:0] paddr, ack_cnt;
  logic [31:0] pwdata, prdata, irq_in, vec_addr, reset_vector, rq;
  logic [SID_W-1:0] sec_sid, sid_in;
  logic [4:0] vec_num;
  int n_mismatch, compares, n_take;

  core_interrupt_control dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ_IN(irq_in),
    .SEC_IRQ(sec_irq), .SEC_SID(sec_sid), .SEC_ACK(sec_ack), .RTI_EXEC(return_from_irq), .CLEAR_IRQ_JUMP_EXEC(jci),
    .VEC_TAKE(vec_take), .VEC_NUM(vec_num), .VEC_ADDR(vec_addr), .RESET_VECTOR(reset_vector));
  sec_model sec (.clk(clk), .rst(rst), .raise(raise), .sid_in(sid_in), .sec_ack(sec_ack),
    .sec_irq(sec_irq), .sec_sid(sec_sid), .ack_cnt(ack_cnt));

  always #50 clk = ~clk;
  always @(posedge clk) if (vec_take === 1'b1) n_take++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_mismatch++;
      stop_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rq, re);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rq, re);
    chk(rq, exp);
  endtask : rd_chk

  task automatic take_chk(input int n, input logic [4:0] num);
    int i;
    i = 0;
    while (n_take < n && i < 20) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk(32'(n_take), 32'(n));
    chk({27'h0, vec_num}, {27'h0, num});
  endtask : take_chk

  // one-cycle return (0) or clear-interrupt jump (1) strobe
  task automatic pulse(input logic j);
    @(posedge clk);
    if (j) jci <= 1'b1;
    else return_from_irq <= 1'b1;
    @(posedge clk);
    jci <= 1'b0;
    return_from_irq <= 1'b0;
    @(posedge clk);
  endtask : pulse

  task automatic kick(input logic [SID_W-1:0] s);
    @(posedge clk);
    raise <= 1'b1;
    sid_in <= s;
    @(posedge clk);
    raise <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : kick

  task automatic stop_test();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  initial begin
    #(3000 * 100);
    n_mismatch++;
    stop_test();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, return_from_irq, jci, raise} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    irq_in = 32'h0;
    sid_in = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (vrows[k]) begin
      wr(OFS_SYSCTL, vrows[k].sel);
      wr(OFS_MASK, 32'h1000_0000);
      wr(OFS_ARITH_STATUS_X, 32'h0000_00a5 + 32'(k));
      wr(OFS_MODE_CONTROL_ONE, 32'h0000_1000);
      wr(OFS_LATCH, 32'h1000_0000);
      take_chk(k + 1, 5'h1c);
      chk(vec_addr, vrows[k].base + 32'h70);
      chk(reset_vector, RESET_ADDR);
      rd_chk(OFS_MODE_CONTROL_ONE, 32'h0);
      rd_chk(OFS_STKTOP, 32'h1000);
      rd_chk(OFS_MASKP, 32'h1000_0000);
      wr(OFS_ARITH_STATUS_X, 32'h0);
      pulse(k[0]);
      rd_chk(OFS_MODE_CONTROL_ONE, 32'h1000);
      rd_chk(OFS_ARITH_STATUS_X, 32'h0000_00a5 + 32'(k));
      rd_chk(OFS_MASKP, 32'h0);
    end
    wr(OFS_MASK, 32'h5000_0000);
    @(posedge clk);
    irq_in <= 32'h5000_0000;
    @(posedge clk);
    irq_in <= 32'h0;
    take_chk(5, 5'h1c);
    pulse(1'b0);
    take_chk(6, 5'h1e);
    pulse(1'b0);
    // system event without self-nesting
    wr(OFS_MASK, 32'h0000_8000);
    kick(8'h5a);
    take_chk(7, SYSTEM_EVENT_IRQ_NUM);
    rd_chk(OFS_SID, 32'h5a);
    wr(OFS_SID, 32'h0);
    repeat (2) @(posedge clk);
    chk({24'h0, ack_cnt}, 32'h1);
    kick(8'h3c);
    rd_chk(OFS_LATCH, 32'h0);
    chk(32'(n_take), 32'h7);
    rd_chk(OFS_SID, 32'h3c);
    wr(OFS_SID, 32'h0);
    pulse(1'b0);
    // self-nesting with global and nest enables
    wr(OFS_MODE_CLEAR_MASK, 32'h0);
    wr(OFS_MODE_CONTROL_TWO, 32'h100);
    wr(OFS_MODE_CONTROL_ONE, 32'h1800);
    kick(8'h11);
    take_chk(8, SYSTEM_EVENT_IRQ_NUM);
    rd_chk(OFS_MASKP, 32'h8000);
    wr(OFS_SID, 32'h0);
    kick(8'h22);
    take_chk(9, SYSTEM_EVENT_IRQ_NUM);
    pulse(1'b0);
    rd_chk(OFS_MASKP, 32'h8000);
    pulse(1'b0);
    rd_chk(OFS_MASKP, 32'h0);
    rd_chk(OFS_MODE_CONTROL_ONE, 32'h1800);
    // second reset in mid-run, then an unmapped access
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_MODE_CLEAR_MASK, MODE_CLEAR_MASK_RST);
    rd_chk(OFS_MODE_CONTROL_ONE, MODE_CONTROL_ONE_RST);
    rd_chk(OFS_MODE_CONTROL_TWO, MODE_CONTROL_TWO_RST);
    rd_chk(OFS_SYSCTL, SYSCTL_RST);
    rd_chk(OFS_STKTOP, 32'h0);
    apb(1'b0, 8'h2c, 32'h0, rq, re);
    chk({31'h0, re}, 32'h1);
    chk(rq, 32'h0);
    stop_test();
  end
endmodule : tb_top
